/* verilog/irq_pkg.sv */
// Purpose: constants for the interrupt enable and flag block
// Assumes: 9-bit register address, 8-bit data
// Notes: address bits 8:7 select a data bank
//
// Notes on behaviour
// (RULE1) control bit 7 passes unmasked interrupts to the core, or blocks all
// (RULE2) control bit 6 passes unmasked peripheral interrupts, or blocks them
// (RULE3) no peripheral enable raises a request without the group enable
// (RULE4) control bit 5 enables the timer0 overflow interrupt
// (RULE5) control bit 4 enables the external pin interrupt
// (RULE6) control bit 3 enables port change; each pin also needs its own enable
// (RULE7) timer0 rollover sets control bit 2 until software clears it
// (RULE8) external pin event sets control bit 1 until software clears it
// (RULE9) a change on port pins 5..0 sets control bit 0 until cleared
// (RULE10) flags set on their event whatever any enable says; the code sets the port change flag only for pins enabled in pinen_r
// (RULE11) software should clear flags before enabling their interrupts
// (RULE12) software should load timer0 before clearing its overflow flag
// (RULE13) peripheral enables: eeprom, adc, capcomp, cmp2, cmp1, osc, timer2, timer1
// (RULE14) eeprom write completion sets peripheral flag bit 7 until cleared
// (RULE15) conversion completion sets peripheral flag bit 6
// (RULE16) capture or compare sets bit 5; unused in pwm mode
// (RULE17) comparator 2 and 1 output changes set bits 4 and 3
// (RULE18) oscillator failure with switch to internal oscillator sets bit 2
// (RULE19) timer2 period match sets bit 1, timer1 overflow sets bit 0
// (RULE20) the control register is reached alike from all four banks
// (RULE21) edge select 1 takes rising, 0 falling external pin edges
// (RULE22) request when global enable and any enabled flag, peripherals gated

package irq_pkg;
  localparam int unsigned AW = 9;
  localparam int unsigned DW = 8;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] CTRL_LOW = 7'h0b;
  localparam logic [8:0] PFLAG_OFS = 9'h00c;
  localparam logic [8:0] PEN_OFS = 9'h08c;
  localparam logic [8:0] PINEN_OFS = 9'h096;
  localparam logic [8:0] EDGE_OFS = 9'h081;
  // ------------------------------------------------------------
  // control, edge and peripheral flag field positions, port width
  // ------------------------------------------------------------
  localparam int unsigned GLOBAL_B = 7;
  localparam int unsigned PGE_B = 6;
  localparam int unsigned T0E_B = 5;
  localparam int unsigned EXE_B = 4;
  localparam int unsigned PCE_B = 3;
  localparam int unsigned T0F_B = 2;
  localparam int unsigned EXF_B = 1;
  localparam int unsigned PCF_B = 0;
  localparam int unsigned EDGE_B = 6;
  localparam int unsigned CAPCOMP_B = 5;
  localparam int unsigned PORT_W = 6;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [5:0] PINEN_RST = 6'h00;
  localparam logic EDGE_RST = 1'b1;
endpackage

/* verilog/sync_edge.sv */
// Purpose: two-stage synchroniser with change detection
// Assumes: inputs are from outside the ref_clk domain
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module sync_edge #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule // sync_edge

/* verilog/sticky_flags.sv */
// Purpose: flag bits set by hardware, written by software
// Assumes: set and write come from the ref_clk domain
// Notes: a set in the cycle of a clearing write wins
`timescale 1ns/1ns
module sticky_flags #(
  parameter int unsigned W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;
  // set wins so an event in the clearing cycle is never lost
  assign flags_nxt = set | (wr ? wdata : flags_r); // RULE10
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
  assign flags = flags_r;
endmodule // sticky_flags

/* verilog/irq_ctrl.sv */
// Purpose: interrupt enables, flags and request to the core
// Assumes: event pulses are one ref_clk cycle wide, pins are async
// Notes: read data stand one cycle after the read strobe, else zero
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module irq_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [8:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic ext_pin,
  input wire logic [5:0] low_port,
  input wire logic comparator2_out,
  input wire logic comparator1_out,
  input wire logic timer0_rollover,
  input wire logic eeprom_done,
  input wire logic conversion_done,
  input wire logic capcomp_event,
  input wire logic capcomp_pwm_mode,
  input wire logic osc_fail,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  output logic irq
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // bank bits 8:7 ignored so every bank reaches one control register
  logic hit_ctrl;
  logic hit_pflag;
  logic hit_pen;
  logic hit_pinen;
  logic hit_edge;
  logic wr_ctrl;
  logic wr_pflag;
  logic wr_pen;
  logic wr_pinen;
  logic wr_edge;
  assign hit_ctrl = (addr[6:0] == irq_pkg::CTRL_LOW); // RULE20
  assign hit_pflag = (addr == irq_pkg::PFLAG_OFS);
  assign hit_pen = (addr == irq_pkg::PEN_OFS);
  assign hit_pinen = (addr == irq_pkg::PINEN_OFS);
  assign hit_edge = (addr == irq_pkg::EDGE_OFS);
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_pflag = wr_en & hit_pflag;
  assign wr_pen = wr_en & hit_pen;
  assign wr_pinen = wr_en & hit_pinen;
  assign wr_edge = wr_en & hit_edge;

  // ------------------------------------------------------------
  // enable registers
  // ------------------------------------------------------------
  logic [4:0] ctrl_en_r;
  logic [7:0] pen_r;
  logic [5:0] pinen_r;
  logic edge_sel_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_r <= irq_pkg::CTRL_RST[7:3];
      pen_r <= irq_pkg::PEN_RST;
      pinen_r <= irq_pkg::PINEN_RST;
      edge_sel_r <= irq_pkg::EDGE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_r <= wr_data[7:3];
      end
      if (wr_pen) begin
        pen_r <= wr_data; // RULE13
      end
      if (wr_pinen) begin
        pinen_r <= wr_data[5:0];
      end
      if (wr_edge) begin
        edge_sel_r <= wr_data[irq_pkg::EDGE_B];
      end
    end
  end

  logic global_irq_enable;
  logic peripheral_group_enable;
  logic timer0_overflow_enable;
  logic ext_pin_irq_enable;
  logic port_change_enable;
  assign global_irq_enable = ctrl_en_r[irq_pkg::GLOBAL_B - 3];
  assign peripheral_group_enable = ctrl_en_r[irq_pkg::PGE_B - 3];
  assign timer0_overflow_enable = ctrl_en_r[irq_pkg::T0E_B - 3];
  assign ext_pin_irq_enable = ctrl_en_r[irq_pkg::EXE_B - 3];
  assign port_change_enable = ctrl_en_r[irq_pkg::PCE_B - 3];

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [8:0] pin_level;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;
  sync_edge #(
    .W(9)
  ) u_pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din({comparator2_out, comparator1_out, ext_pin, low_port}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------
  logic ext_event;
  logic port_event;
  logic cmp2_event;
  logic cmp1_event;
  logic capcomp_set;
  logic [5:0] port_change;
  assign ext_event = edge_sel_r ? pin_rise[6] : pin_fall[6]; // RULE21
  // only pins with their own change enable may flag a change
  assign port_change = (pin_rise[5:0] | pin_fall[5:0]) & pinen_r; // RULE6
  assign port_event = |port_change; // RULE9
  assign cmp2_event = pin_rise[8] | pin_fall[8]; // RULE17
  assign cmp1_event = pin_rise[7] | pin_fall[7]; // RULE17
  // in pwm mode the capture/compare unit has no flag event
  assign capcomp_set = capcomp_event & ~capcomp_pwm_mode; // RULE16

  // ------------------------------------------------------------
  // flags
  // ------------------------------------------------------------
  logic [2:0] core_set;
  logic [2:0] core_flags;
  logic [7:0] per_set;
  logic [7:0] per_flags;
  assign core_set = {timer0_rollover, ext_event, port_event}; // RULE7 RULE8
  assign per_set = {eeprom_done, conversion_done, capcomp_set, cmp2_event,
                    cmp1_event, osc_fail, timer2_match, timer1_overflow}; // RULE14 RULE15 RULE18 RULE19

  sticky_flags #(
    .W(3)
  ) u_core_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(core_set),
    .wr(wr_ctrl),
    .wdata(wr_data[2:0]),
    .flags(core_flags)
  );

  sticky_flags #(
    .W(8)
  ) u_per_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(per_set),
    .wr(wr_pflag),
    .wdata(wr_data),
    .flags(per_flags)
  );

  logic timer0_overflow_flag;
  logic ext_pin_irq_flag;
  logic port_change_flag;
  assign timer0_overflow_flag = core_flags[irq_pkg::T0F_B];
  assign ext_pin_irq_flag = core_flags[irq_pkg::EXF_B];
  assign port_change_flag = core_flags[irq_pkg::PCF_B];

  // ------------------------------------------------------------
  // request to the core
  // ------------------------------------------------------------
  logic core_pend;
  logic per_pend;
  logic irq_nxt;
  logic irq_r;
  assign core_pend = (timer0_overflow_enable & timer0_overflow_flag) // RULE4
                   | (ext_pin_irq_enable & ext_pin_irq_flag) // RULE5
                   | (port_change_enable & port_change_flag); // RULE6
  assign per_pend = peripheral_group_enable & (|(pen_r & per_flags)); // RULE2 RULE3
  assign irq_nxt = global_irq_enable & (core_pend | per_pend); // RULE1 RULE22
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end
  assign irq = irq_r;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped addresses read zero, and idle cycles read zero too
  logic [7:0] rd_sel;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  assign rd_sel = hit_ctrl ? {ctrl_en_r, core_flags} :
                  hit_pflag ? per_flags :
                  hit_pen ? pen_r :
                  hit_pinen ? {2'h0, pinen_r} :
                  hit_edge ? {1'b0, edge_sel_r, 6'h00} : 8'h00;
  assign rd_data_nxt = rd_en ? rd_sel : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end
  assign rd_data = rd_data_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence ctrl_write_hi_bank;
    wr_en && addr == 9'h18b;
  endsequence

  sequence ctrl_read_lo_bank;
    rd_en && !wr_en && addr == 9'h00b;
  endsequence

  sequence ext_rise_sel;
    edge_sel_r && pin_level[6] && !$past(pin_level[6]);
  endsequence

  sequence ext_fall_sel;
    !edge_sel_r && !pin_level[6] && $past(pin_level[6]);
  endsequence

  sequence cmp2_change;
    pin_level[8] != $past(pin_level[8]);
  endsequence

  sequence cmp1_change;
    pin_level[7] != $past(pin_level[7]);
  endsequence

  sequence port_pin_change;
    |((pin_level[5:0] ^ $past(pin_level[5:0])) & pinen_r);
  endsequence

  gie_block_a: assert property ( // RULE1
    !global_irq_enable |=> !irq
  ) else $error("request raised with global enable clear");

  pge_block_a: assert property ( // RULE3
    !peripheral_group_enable && !core_pend |=> !irq
  ) else $error("peripheral request passed without group enable");

  t0_request_a: assert property ( // RULE4
    global_irq_enable && timer0_overflow_enable && timer0_overflow_flag |=> irq
  ) else $error("timer0 request not raised");

  t0_flag_set_a: assert property ( // RULE7
    timer0_rollover |=> timer0_overflow_flag
  ) else $error("timer0 flag not set on rollover");

  ext_rise_flag_a: assert property ( // RULE21
    ext_rise_sel |=> ext_pin_irq_flag
  ) else $error("rising external edge not flagged");

  ext_flag_hold_a: assert property ( // RULE8
    ext_pin_irq_flag && !wr_ctrl |=> ext_pin_irq_flag
  ) else $error("external flag dropped without a write");

  eeprom_flag_set_a: assert property ( // RULE14
    eeprom_done && !global_irq_enable |=> per_flags[7]
  ) else $error("eeprom flag not set while disabled");

  pwm_no_flag_a: assert property ( // RULE16
    capcomp_pwm_mode && !per_flags[irq_pkg::CAPCOMP_B] && !wr_pflag
    |=> !per_flags[irq_pkg::CAPCOMP_B]
  ) else $error("capcomp flag set in pwm mode");

  bank_alias_a: assert property ( // RULE20
    ctrl_write_hi_bank ##1 ctrl_read_lo_bank |=> rd_data[7:3] == $past(wr_data[7:3], 2)
  ) else $error("control enables differ between banks");

  port_mask_a: assert property ( // RULE6
    pinen_r == 6'h00 && !port_change_flag && !wr_ctrl |=> !port_change_flag
  ) else $error("port change flagged with all pins disabled");

  pge_pass_a: assert property ( // RULE2
    global_irq_enable && peripheral_group_enable && |(pen_r & per_flags) |=> irq
  ) else $error("enabled peripheral request not raised");

  ext_request_a: assert property ( // RULE5
    global_irq_enable && ext_pin_irq_enable && ext_pin_irq_flag |=> irq
  ) else $error("external pin request not raised");

  port_request_a: assert property ( // RULE6
    global_irq_enable && port_change_enable && port_change_flag |=> irq
  ) else $error("port change request not raised");

  ext_fall_flag_a: assert property ( // RULE8
    ext_fall_sel |=> ext_pin_irq_flag
  ) else $error("falling external edge not flagged");

  ext_wrong_edge_a: assert property ( // RULE21
    edge_sel_r && !(pin_level[6] && !$past(pin_level[6])) && !wr_ctrl && !ext_pin_irq_flag
    |=> !ext_pin_irq_flag
  ) else $error("external flag set without a rising edge");

  port_flag_set_a: assert property ( // RULE9
    port_pin_change |=> port_change_flag
  ) else $error("enabled port pin change not flagged");

  t0_flag_hold_a: assert property ( // RULE7
    timer0_overflow_flag && !wr_ctrl |=> timer0_overflow_flag
  ) else $error("timer0 flag dropped without a write");

  per_flag_hold_a: assert property ( // RULE19
    !wr_pflag |=> (per_flags & $past(per_flags)) == $past(per_flags)
  ) else $error("peripheral flag dropped without a write");

  flag_any_enable_a: assert property ( // RULE10
    per_set != 8'h00 |=> (per_flags & $past(per_set)) == $past(per_set)
  ) else $error("peripheral event lost");

  pen_write_a: assert property ( // RULE13
    wr_pen |=> pen_r == $past(wr_data)
  ) else $error("peripheral enables not written");

  conv_flag_set_a: assert property ( // RULE15
    conversion_done |=> per_flags[6]
  ) else $error("conversion flag not set");

  capcomp_flag_set_a: assert property ( // RULE16
    capcomp_event && !capcomp_pwm_mode |=> per_flags[irq_pkg::CAPCOMP_B]
  ) else $error("capcomp flag not set outside pwm mode");

  cmp2_flag_set_a: assert property ( // RULE17
    cmp2_change |=> per_flags[4]
  ) else $error("comparator 2 change not flagged");

  cmp1_flag_set_a: assert property ( // RULE17
    cmp1_change |=> per_flags[3]
  ) else $error("comparator 1 change not flagged");

  osc_flag_set_a: assert property ( // RULE18
    osc_fail |=> per_flags[2]
  ) else $error("oscillator fail not flagged");

  timer2_flag_set_a: assert property ( // RULE19
    timer2_match |=> per_flags[1]
  ) else $error("timer2 match not flagged");

  timer1_flag_set_a: assert property ( // RULE19
    timer1_overflow |=> per_flags[0]
  ) else $error("timer1 overflow not flagged");

endmodule // irq_ctrl

/* testbench/event_source.sv */
// Purpose: peripheral event sources beside the interrupt block
// Assumes: one request at a time from the bench
// Notes: a request gives one pulse one cycle later
`timescale 1ns/1ns
module event_source (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [2:0] sel,
  output logic [6:0] pulses
);
  // ----------------------------------------
  // one-cycle event pulses
  // ----------------------------------------
  // wider pulses would mask a set-versus-clear race
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulses <= 7'h00;
    end else begin
      pulses <= fire ? (7'h01 << sel) : 7'h00;
    end
  end
endmodule // event_source

/* testbench/core_interrupt_enable_flags_test.sv */
// Purpose: self-checking bench for the interrupt enable and flag block
// Assumes: reference model in integers, register bus without wait states
// Notes: pins toggle far from edges of interest, so sync latency is covered by 5 cycles
`timescale 1ns/1ns
module core_interrupt_enable_flags_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic ext_pin = 1'b0;
  logic [5:0] low_port = 6'h00;
  logic cmp2 = 1'b0;
  logic cmp1 = 1'b0;
  logic pwm_mode = 1'b0;
  logic fire = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [6:0] pulses;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  int mc = 0;
  int mf = 0;
  int me = 0;
  int i;
  int b;
  int pbit [6] = '{0, 1, 2, 5, 6, 7};
  logic [8:0] ra [6] = '{9'h00b, 9'h00c, 9'h08c, 9'h096, 9'h081, 9'h123};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};

  always #10 ref_clk = ~ref_clk;

  event_source u_event_source (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .sel(sel), .pulses(pulses));

  irq_ctrl u_irq_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .ext_pin(ext_pin), .low_port(low_port), .comparator2_out(cmp2),
    .comparator1_out(cmp1), .timer0_rollover(pulses[6]), .eeprom_done(pulses[5]),
    .conversion_done(pulses[4]), .capcomp_event(pulses[3]), .capcomp_pwm_mode(pwm_mode),
    .osc_fail(pulses[2]), .timer2_match(pulses[1]), .timer1_overflow(pulses[0]), .irq(irq)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= w;
    rd_en <= ~w;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask

  // model follows writes to control, peripheral flags and peripheral enables; control aliases in all banks
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a[6:0] == 7'h0b) mc = d;
    if (a == 9'h00c) mf = d;
    if (a == 9'h08c) me = d;
  endtask

  task automatic rd(input logic [8:0] a, input int x);
    bus(1'b0, a, 8'h00);
    check(rd_data, x[7:0]);
  endtask

  task automatic chk_irq();
    logic e;
    e = mc[7] & ((mc[5] & mc[2]) | (mc[4] & mc[1]) | (mc[3] & mc[0]) | (mc[6] & |(me[7:0] & mf[7:0])));
    repeat (2) @(posedge ref_clk);
    #1;
    check({7'h00, irq}, {7'h00, e});
  endtask

  task automatic fire_ev(input int s);
    @(posedge ref_clk);
    fire <= 1'b1;
    sel <= s[2:0];
    @(posedge ref_clk);
    fire <= 1'b0;
    if (s == 6) mc = mc | 4;
    else if (s != 3 || !pwm_mode) mf = mf | (1 << pbit[s]);
  endtask

  task automatic pin_step(input logic e, input logic p, input int x);
    wr(9'h081, {1'b0, e, 6'h00});
    wr(9'h00b, 8'h00);
    @(posedge ref_clk);
    ext_pin <= p;
    repeat (5) @(posedge ref_clk);
    rd(9'h00b, x);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    b = $urandom(75434);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(9'h123, 8'hff);
    rd(9'h123, 0);
    for (i = 0; i < 7; i++) begin
      fire_ev(i);
      rd(9'h00c, mf);
      rd(9'h00b, mc);
    end
    wr(9'h00c, 8'h00);
    @(posedge ref_clk);
    pwm_mode <= 1'b1;
    fire_ev(3);
    rd(9'h00c, mf);
    // flags cleared before enabling, as software must
    wr(9'h08c, 8'h01);
    // timer0 source stays quiet, as if loaded, before its flag is cleared
    wr(9'h00b, 8'hc0);
    chk_irq();
    fire_ev(0);
    chk_irq();
    wr(9'h00b, 8'h80);
    chk_irq();
    for (i = 0; i < 24; i++) begin
      b = $urandom;
      wr({b[1:0], 7'h0b}, 8'($urandom));
      wr(9'h08c, 8'($urandom));
      wr(9'h00c, 8'($urandom));
      chk_irq();
      rd({b[3:2], 7'h0b}, mc);
      rd(9'h08c, me);
    end
    pin_step(1'b1, 1'b1, 2);
    pin_step(1'b1, 1'b0, 0);
    pin_step(1'b0, 1'b1, 0);
    pin_step(1'b0, 1'b0, 2);
    wr(9'h096, 8'h04);
    wr(9'h00b, 8'h00);
    wr(9'h00c, 8'h00);
    @(posedge ref_clk);
    low_port <= 6'h08;
    repeat (5) @(posedge ref_clk);
    rd(9'h00b, 0);
    @(posedge ref_clk);
    low_port <= 6'h0c;
    cmp1 <= 1'b1;
    cmp2 <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(9'h00b, 1);
    rd(9'h00c, 8'h18);
    // back-to-back write in bank 3 and read in bank 0
    @(posedge ref_clk);
    addr <= 9'h18b;
    wr_data <= 8'ha8;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    addr <= 9'h00b;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, 8'ha8);
    finish_test();
  end

  // run needs under 500 cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
endmodule // core_interrupt_enable_flags_test
